//--- dpc_path_ctrl.v
// Design decision made here: the AXI4-Lite slave port.
`include "dpc_regs.vh"
`default_nettype none

// What this block does
// - Low-latency invert bit negates incoming samples
// - Main gate code picks threshold; 111 disables
// - Reference path has own gate field
// - Main de-emphasis enable, base rates only
// - Reference path has own de-emphasis enable
// - Follow-master bit ties reference to master volume
// - Config field: interpolate, hold, tracking, reserved
// - Tracking mode always uses interpolation filter
// - Per-channel invert; reference invert dead when tracking
// - Reference attenuation: soft ramp or immediate
// - Main attenuation: soft ramp or immediate
// - Low-latency mute bit silences that path
// - Per-channel mute bit silences channel
// - Ramp bit drives common-mode level down
// - Tracking gain one or two in mode
// - Per-channel power-down bit
// - Mute step interval 1x/4x/16x/64x base
// - Minimum delay is two to code
// - Maximum delay is two to code
module dpc_path_ctrl
(
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Tracking mode strap from the tracking control block
    input  wire        tracking_mode_sel,
    // Low-latency sample stream, one sample per valid
    input  wire [23:0] lowlat_in,
    input  wire        lowlat_in_valid,
    output reg  [23:0] lowlat_out,
    output reg         lowlat_out_valid,
    // Decoded path controls
    output reg  [2:0]  main_gate_thr,
    output reg         main_gate_on,
    output reg  [2:0]  ref_gate_thr,
    output reg         ref_gate_on,
    output reg         main_out_deemph_en,
    output reg         ref_out_deemph_en,
    output reg         ref_out_follow_master,
    output reg         ref_filter_hold,
    output reg         ref_tracking_on,
    output reg  [4:0]  out_channel_invert,
    output reg  [4:0]  out_channel_mute,
    output reg  [4:0]  out_channel_powerdown,
    output reg         tracking_gain_two,
    output reg         midrail_ramp_down,
    output reg  [7:0]  common_mode_level,
    // Ramped attenuation per group: main channels and reference path
    output reg  [7:0]  main_level,
    output reg  [7:0]  ref_level,
    output reg         ramp_step
);

    // Register storage
    reg  [7:0]  lowlat_q;
    reg  [7:0]  ctrl_one_q;
    reg  [7:0]  ctrl_two_q;
    reg  [7:0]  att_mute_q;
    reg  [7:0]  pwr_gain_q;
    reg  [7:0]  ramp_tim_q;
    reg  [7:0]  target_q;
    // Write channel capture, either order
    reg         aw_held_q;
    reg         w_held_q;
    reg  [7:0]  aw_idx_q;
    reg  [7:0]  w_data_q;
    reg         w_lane_q;
    reg         aw_word_ok_q;
    // Decode of the held address; only used while both halves are held
    wire        wr_map  = aw_word_ok_q && (aw_idx_q >= `DPC_IDX_LOWLAT) && (aw_idx_q <= `DPC_IDX_LEVEL);
    // Ramp engine and tracking strap synchroniser state
    reg  [13:0] base_cnt_q;
    reg  [7:0]  tick_cnt_q;
    reg  [7:0]  wait_cnt_q;
    reg  [7:0]  cm_q;
    reg         trk_s1_q;
    reg         trk_s2_q;
    reg         trk_s3_q;
    reg         trk_q;
    // Reference path decode and base tick; the reload is cut to the counter width
    wire        ref_track = (ctrl_one_q[1:0] == `DPC_CFG_TRACK);
    wire        base_tick = (base_cnt_q == 14'd0);
    wire [31:0] base_load = `DPC_BASE_CYC - 1;
    // Ready pulses: take each channel once; hold until the response is accepted
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_idx_q      <= 8'h00;
            aw_word_ok_q  <= 1'b0;
            w_data_q      <= 8'h00;
            w_lane_q      <= 1'b0;
        end
        else
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_held_q && !s_axi_awready)
            begin
                s_axi_awready <= 1'b1;
                aw_held_q     <= 1'b1;
                aw_idx_q      <= s_axi_awaddr[9:2];
                aw_word_ok_q  <= (s_axi_awaddr[31:10] == 22'h000000);
            end
            if (s_axi_wvalid && !w_held_q && !s_axi_wready)
            begin
                s_axi_wready <= 1'b1;
                w_held_q     <= 1'b1;
                w_data_q     <= s_axi_wdata[7:0];
                w_lane_q     <= s_axi_wstrb[0];
            end
            if (aw_held_q && w_held_q && !s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? 2'b00 : 2'b10;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
            end
        end
    end

    // Register writes happen once both halves are held
    wire        commit = aw_held_q && w_held_q && !s_axi_bvalid && w_lane_q && wr_map;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lowlat_q   <= `DPC_RST_LOWLAT;
            ctrl_one_q <= `DPC_RST_CTRL_ONE;
            ctrl_two_q <= `DPC_RST_CTRL_TWO;
            att_mute_q <= `DPC_RST_ATT_MUTE;
            pwr_gain_q <= `DPC_RST_PWR_GAIN;
            ramp_tim_q <= `DPC_RST_RAMP_TIM;
            target_q   <= `DPC_RST_LEVEL;
        end
        else if (commit)
        begin
            case (aw_idx_q)
                `DPC_IDX_LOWLAT:   lowlat_q   <= w_data_q & `DPC_WMASK_LOWLAT;
                `DPC_IDX_CTRL_ONE: ctrl_one_q <= w_data_q;
                `DPC_IDX_CTRL_TWO: ctrl_two_q <= w_data_q;
                `DPC_IDX_ATT_MUTE: att_mute_q <= w_data_q;
                `DPC_IDX_PWR_GAIN: pwr_gain_q <= w_data_q & `DPC_WMASK_PWRGAIN;
                `DPC_IDX_RAMP_TIM: ramp_tim_q <= w_data_q;
                `DPC_IDX_LEVEL:    target_q   <= w_data_q;
                default:           target_q   <= target_q;
            endcase
        end
    end
    // Read channel: one-cycle accept, data in the same cycle as the accept
    reg  [7:0]  rd_byte;
    always @*
    begin
        case (s_axi_araddr[9:2])
            `DPC_IDX_LOWLAT:   rd_byte = lowlat_q;
            `DPC_IDX_CTRL_ONE: rd_byte = ctrl_one_q;
            `DPC_IDX_CTRL_TWO: rd_byte = ctrl_two_q;
            `DPC_IDX_ATT_MUTE: rd_byte = att_mute_q;
            `DPC_IDX_PWR_GAIN: rd_byte = pwr_gain_q;
            `DPC_IDX_RAMP_TIM: rd_byte = ramp_tim_q;
            `DPC_IDX_LEVEL:    rd_byte = target_q;
            `DPC_IDX_STATUS:   rd_byte = main_level;
            default:           rd_byte = 8'h00;
        endcase
    end
    wire        rd_map = (s_axi_araddr[31:10] == 22'h000000) &&
                         (s_axi_araddr[9:2] >= `DPC_IDX_LOWLAT) && (s_axi_araddr[9:2] <= `DPC_IDX_STATUS);
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'b00;
        end
        else
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, rd_map ? rd_byte : 8'h00};
                s_axi_rresp   <= rd_map ? 2'b00 : 2'b10;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Strap from outside the clock domain: three flops, change once stages two and three agree
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trk_s1_q <= 1'b0;
            trk_s2_q <= 1'b0;
            trk_s3_q <= 1'b0;
            trk_q    <= 1'b0;
        end
        else
        begin
            trk_s1_q <= tracking_mode_sel;
            trk_s2_q <= trk_s1_q;
            trk_s3_q <= trk_s2_q;
            if (trk_s2_q == trk_s3_q)
                trk_q <= trk_s3_q;
        end
    end
    // Low-latency data path, one cycle of latency
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lowlat_out       <= 24'h000000;
            lowlat_out_valid <= 1'b0;
        end
        else
        begin
            lowlat_out_valid <= lowlat_in_valid;
            if (att_mute_q[5])
                lowlat_out <= 24'h000000;
            // any set invert bit negates; the single stream carries no channel index
            else if (|lowlat_q[3:0])
                lowlat_out <= 24'h000000 - lowlat_in;
            else
                lowlat_out <= lowlat_in;
        end
    end

    // Decoded control outputs, registered
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            main_gate_thr         <= 3'h7; // Same as the gate-off reset code
            main_gate_on          <= 1'b0;
            ref_gate_thr          <= 3'h7; // Same as the gate-off reset code
            ref_gate_on           <= 1'b0;
            main_out_deemph_en    <= 1'b0;
            ref_out_deemph_en     <= 1'b0;
            ref_out_follow_master <= 1'b0;
            ref_filter_hold       <= 1'b0;
            ref_tracking_on       <= 1'b0;
            out_channel_invert    <= 5'h00;
            out_channel_mute      <= 5'h1F;
            out_channel_powerdown <= 5'h1F;
            tracking_gain_two     <= 1'b0;
            midrail_ramp_down     <= 1'b0;
        end
        else
        begin
            main_gate_thr         <= ctrl_one_q[7:5];
            main_gate_on          <= ctrl_one_q[7:5] != `DPC_GATE_OFF;
            ref_gate_thr          <= ctrl_two_q[7:5];
            ref_gate_on           <= ctrl_two_q[7:5] != `DPC_GATE_OFF;
            main_out_deemph_en    <= ctrl_one_q[4];
            ref_out_deemph_en     <= ctrl_one_q[3];
            ref_out_follow_master <= ctrl_one_q[2];
            // hold filter only for code 01
            ref_filter_hold       <= ctrl_one_q[1:0] == `DPC_CFG_HOLD;
            ref_tracking_on       <= ref_track;
            out_channel_invert    <= {ctrl_two_q[4] & ~ref_track, ctrl_two_q[3:0]};
            out_channel_mute      <= att_mute_q[4:0];
            out_channel_powerdown <= pwr_gain_q[4:0];
            // gain two only in tracking mode 1
            tracking_gain_two     <= trk_q & pwr_gain_q[6];
            midrail_ramp_down     <= pwr_gain_q[7];
        end
    end

    // Base period divider and power-of-two step scaling
    wire [7:0]  step_len = (ramp_tim_q[7:6] == 2'd0) ? 8'd1 :
                           (ramp_tim_q[7:6] == 2'd1) ? 8'd4 :
                           (ramp_tim_q[7:6] == 2'd2) ? 8'd16 : 8'd64;
    // minimum wait two to the code
    wire [7:0]  min_len  = 8'd1 << ramp_tim_q[5:3];
    // maximum wait two to the code
    wire [7:0]  max_len  = 8'd1 << ramp_tim_q[2:0];
    // Muting steps use the mute interval, level steps the smaller of min and max
    wire        muting   = out_channel_mute[0] || (target_q == `DPC_RAMP_FULL);
    wire [7:0]  lvl_len  = (min_len > max_len) ? max_len : min_len;
    wire [7:0]  cur_len  = muting ? step_len : lvl_len;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            base_cnt_q <= 14'd0;
            tick_cnt_q <= 8'd0;
            ramp_step  <= 1'b0;
        end
        else
        begin
            ramp_step <= 1'b0;
            base_cnt_q <= base_tick ? base_load[13:0] : base_cnt_q - 14'd1;
            if (base_tick)
            begin
                // step every chosen number of base periods
                if (tick_cnt_q + 8'd1 >= cur_len)
                begin
                    tick_cnt_q <= 8'd0;
                    ramp_step  <= 1'b1;
                end
                else
                    tick_cnt_q <= tick_cnt_q + 8'd1;
            end
        end
    end
    // Level trackers: soft ramp one step per tick, or jump
    wire        main_mute_all = &out_channel_mute[3:0];
    wire [7:0]  main_goal = main_mute_all ? `DPC_RAMP_FULL : target_q;
    wire [7:0]  ref_goal  = out_channel_mute[4] ? `DPC_RAMP_FULL : target_q;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            main_level        <= `DPC_RAMP_FULL;
            ref_level         <= `DPC_RAMP_FULL;
            cm_q              <= 8'h80;
            common_mode_level <= 8'h80;
        end
        else
        begin
            if (att_mute_q[6])
                main_level <= main_goal;
            else if (ramp_step && main_level != main_goal)
                main_level <= main_level < main_goal ? main_level + 8'd1 : main_level - 8'd1;
            if (att_mute_q[7])
                ref_level <= ref_goal;
            else if (ramp_step && ref_level != ref_goal)
                ref_level <= ref_level < ref_goal ? ref_level + 8'd1 : ref_level - 8'd1;
            // ramp toward ground, back to half supply
            if (base_tick)
            begin
                if (midrail_ramp_down && cm_q != 8'h00)
                    cm_q <= cm_q - 8'd1;
                else if (!midrail_ramp_down && cm_q != 8'h80)
                    cm_q <= cm_q + 8'd1;
            end
            common_mode_level <= cm_q;
        end
    end

endmodule

`default_nettype wire

//--- dpc_path_ctrl_assertions.sv
`default_nettype none
module dpc_path_ctrl_chk
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus answers
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Path controls
    input wire logic        lowlat_in_valid,
    input wire logic        lowlat_out_valid,
    input wire logic [2:0]  main_gate_thr,
    input wire logic        main_gate_on,
    input wire logic [2:0]  ref_gate_thr,
    input wire logic        ref_gate_on,
    input wire logic        ref_filter_hold,
    input wire logic        ref_tracking_on,
    input wire logic [4:0]  out_channel_invert,
    input wire logic        tracking_mode_sel,
    input wire logic        tracking_gain_two,
    input wire logic        midrail_ramp_down,
    input wire logic [7:0]  common_mode_level,
    input wire logic        ramp_step
);
    timeunit 1ns;
    timeprecision 1ns;
    // One domain, so clock and reset are stated once
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Answers waiting on the master
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence s_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    // Answers must not vanish or change before they are taken
    chk_bresp_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    chk_rdata_hold: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    chk_main_gate: assert property (main_gate_on == (main_gate_thr != 3'h7))
        else $error("main gate decode wrong");
    chk_ref_gate: assert property (ref_gate_on == (ref_gate_thr != 3'h7))
        else $error("reference gate decode wrong");
    chk_track_interp: assert property (ref_tracking_on |-> !ref_filter_hold)
        else $error("hold filter in tracking mode");
    chk_track_inv: assert property (ref_tracking_on |-> !out_channel_invert[4])
        else $error("reference invert active in tracking mode");
    chk_lowlat_lat: assert property (lowlat_in_valid |=> lowlat_out_valid)
        else $error("low-latency sample lost");
    chk_gain_sync: assert property ($rose(tracking_gain_two) |-> $past(tracking_mode_sel))
        else $error("gain two without tracking mode");
    chk_midrail_down: assert property (midrail_ramp_down && $past(midrail_ramp_down)
        |=> common_mode_level <= $past(common_mode_level))
        else $error("common-mode level rose while ramping down");
    // Steps can never come within eight cycles of each other
    chk_step_space: assert property (ramp_step |=> !ramp_step [*8])
        else $error("ramp steps too close");
endmodule

bind dpc_path_ctrl dpc_path_ctrl_chk u_chk
(
    .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .lowlat_in_valid(lowlat_in_valid), .lowlat_out_valid(lowlat_out_valid),
    .main_gate_thr(main_gate_thr), .main_gate_on(main_gate_on), .ref_gate_thr(ref_gate_thr),
    .ref_gate_on(ref_gate_on), .ref_filter_hold(ref_filter_hold), .ref_tracking_on(ref_tracking_on),
    .out_channel_invert(out_channel_invert), .tracking_mode_sel(tracking_mode_sel),
    .tracking_gain_two(tracking_gain_two), .midrail_ramp_down(midrail_ramp_down),
    .common_mode_level(common_mode_level), .ramp_step(ramp_step)
);
`default_nettype wire

//--- dpc_regs.vh
`ifndef DPC_REGS_VH
`define DPC_REGS_VH
// Register indices as printed; byte address is four times the index
`define DPC_IDX_LOWLAT    8'h11
`define DPC_IDX_CTRL_ONE  8'h12
`define DPC_IDX_CTRL_TWO  8'h13
`define DPC_IDX_ATT_MUTE  8'h14
`define DPC_IDX_PWR_GAIN  8'h15
`define DPC_IDX_RAMP_TIM  8'h16
`define DPC_IDX_LEVEL     8'h17
`define DPC_IDX_STATUS    8'h18
// Reset values
`define DPC_RST_LOWLAT    8'h00
`define DPC_RST_CTRL_ONE  8'hFC
`define DPC_RST_CTRL_TWO  8'hE0
`define DPC_RST_ATT_MUTE  8'h1F
`define DPC_RST_PWR_GAIN  8'h1F
`define DPC_RST_RAMP_TIM  8'h00
`define DPC_RST_LEVEL     8'h10
// Writable bit masks (reserved bits stay zero)
`define DPC_WMASK_LOWLAT  8'h0F
`define DPC_WMASK_PWRGAIN 8'hDF
// Field codes
`define DPC_GATE_OFF      3'h7
`define DPC_CFG_INTERP    2'h0
`define DPC_CFG_HOLD      2'h1
`define DPC_CFG_TRACK     2'h2
// Timing: base period of the ramp engine
`define DPC_BASE_NS       1000
`define DPC_CLK_NS        50
`define DPC_BASE_CYC      (`DPC_BASE_NS / `DPC_CLK_NS)
`define DPC_RAMP_FULL     8'hFF
`endif

//--- test_dpc_path_ctrl.sv
`include "dpc_regs.vh"
`default_nettype none
module test_dpc_path_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, tracking_mode_sel = 0, lowlat_in_valid = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lowlat_out_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [23:0] lowlat_in = 0, lowlat_out;
    logic [2:0] main_gate_thr, ref_gate_thr;
    logic main_gate_on, ref_gate_on, main_out_deemph_en, ref_out_deemph_en, ref_out_follow_master;
    logic ref_filter_hold, ref_tracking_on, tracking_gain_two, midrail_ramp_down, ramp_step;
    logic [4:0] out_channel_invert, out_channel_mute, out_channel_powerdown;
    logic [7:0] common_mode_level, main_level, ref_level;
    int mismatches = 0, total_checks = 0, cyc = 0;

    dpc_path_ctrl uut (.*);

    // Clock of 50 ns period
    always #25 aclk = ~aclk;
    // Hang guard, far beyond the longest ramp measurement
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write one register; address and data offered together, released as taken
    task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] rs);
        logic a, w;
        a = 0;
        w = 0;
        @(posedge aclk);
        s_axi_awaddr <= {22'h0, i, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(a && w))
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
            begin
                a = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1)
            begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // Let decoded outputs settle
        repeat (3) @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= {22'h0, i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic t_regs();
        logic [7:0] rst [6] = '{`DPC_RST_LOWLAT, `DPC_RST_CTRL_ONE, `DPC_RST_CTRL_TWO,
                                 `DPC_RST_ATT_MUTE, `DPC_RST_PWR_GAIN, `DPC_RST_RAMP_TIM};
        logic [7:0] msk [6] = '{`DPC_WMASK_LOWLAT, 8'hFF, 8'hFF, 8'hFF, `DPC_WMASK_PWRGAIN, 8'hFF};
        logic [31:0] d;
        chk(out_channel_mute, 5'h1F);
        chk(out_channel_powerdown, 5'h1F);
        for (int k = 0; k < 6; k++)
        begin
            rd(8'h11 + k[7:0], d, r);
            chk(d, {24'h0, rst[k]});
            wr(8'h11 + k[7:0], 8'hA6, r);
            rd(8'h11 + k[7:0], d, r);
            chk(d, {24'h0, 8'hA6 & msk[k]});
        end
        wr(8'h19, 8'hFF, r);
        chk(r, 2'h2);
        rd(8'h40, d, r);
        chk(r, 2'h2);
    endtask

    task automatic t_decode();
        for (int g = 0; g < 8; g++)
        begin
            wr(8'h12, {g[2:0], 5'h0}, r);
            wr(8'h13, {g[2:0], 5'h0}, r);
            chk({main_gate_thr, main_gate_on}, {g[2:0], g != 7});
            chk({ref_gate_thr, ref_gate_on}, {g[2:0], g != 7});
        end
        wr(8'h12, 8'h1C, r);
        chk({main_out_deemph_en, ref_out_deemph_en, ref_out_follow_master}, 3'h7);
        wr(8'h13, 8'h1F, r);
        for (int c = 0; c < 3; c++)
        begin
            wr(8'h12, {6'h0, c[1:0]}, r);
            chk({ref_filter_hold, ref_tracking_on}, {c == 1, c == 2});
            chk(out_channel_invert, (c == 2) ? 5'h0F : 5'h1F);
        end
        wr(8'h12, 8'h00, r);
        chk({main_out_deemph_en, ref_out_deemph_en, ref_out_follow_master}, 3'h0);
    endtask

    task automatic t_paths();
        logic [23:0] s;
        logic [7:0] v;
        s = 24'h123456;
        wr(8'h14, 8'h0A, r);
        chk(out_channel_mute, 5'h0A);
        wr(8'h11, 8'h01, r);
        for (int m = 0; m < 2; m++)
        begin
            wr(8'h14, {2'h0, m[0], 5'h0}, r);
            lowlat_in <= s;
            lowlat_in_valid <= 1'b1;
            @(posedge aclk);
            lowlat_in_valid <= 1'b0;
            // Output stands for one cycle only; look at it mid-cycle
            @(negedge aclk);
            chk({lowlat_out_valid, lowlat_out}, {1'b1, m ? 24'h0 : -s});
        end
        wr(8'h15, 8'h55, r);
        chk({tracking_gain_two, out_channel_powerdown}, {1'b0, 5'h15});
        tracking_mode_sel <= 1'b1;
        repeat (8) @(posedge aclk);
        chk(tracking_gain_two, 1'b1);
        wr(8'h15, 8'h80, r);
        v = common_mode_level;
        repeat (80) @(posedge aclk);
        chk(common_mode_level < v, 1'b1);
    endtask

    // Spacing in cycles between two ramp steps
    task automatic gap(output int n);
        while (ramp_step !== 1'b1) @(posedge aclk);
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (ramp_step !== 1'b1);
    endtask

    task automatic t_ramp();
        int n;
        logic [7:0] g;
        wr(8'h14, 8'hC0, r);
        wr(8'h17, 8'h20, r);
        chk({main_level, ref_level}, 16'h2020);
        for (int k = 0; k < 3; k++)
        begin
            g = (k % 2) ? 8'h20 : 8'h40;
            wr(8'h16, {2'h0, k[2:0], k[2:0]}, r);
            wr(8'h14, 8'h80, r);
            wr(8'h17, g, r);
            chk({main_level != g, ref_level}, {1'b1, g});
            gap(n);
            chk(n, (1 << k) * `DPC_BASE_CYC);
            wr(8'h14, 8'hC0, r);
        end
        // Channel one muted: mute interval code 01 sets the spacing
        wr(8'h16, 8'h40, r);
        wr(8'h14, 8'h81, r);
        gap(n);
        chk(n, 4 * `DPC_BASE_CYC);
    endtask

    // ramp bit set by the host, then a reset in mid-run
    task automatic t_reset();
        logic [31:0] d;
        wr(8'h15, 8'h80, r);
        chk(midrail_ramp_down, 1'b1);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk({midrail_ramp_down, common_mode_level, main_level}, {1'b0, 8'h80, 8'hFF});
        rd(8'h15, d, r);
        chk(d, {24'h0, `DPC_RST_PWR_GAIN});
    endtask

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_decode();
        t_paths();
        t_ramp();
        t_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
